// ==== logic/sppa_pkg.sv ====
package sppa_pkg;

  // Default bus widths and storage sizes
  localparam int SPPA_ADR_W     = 8;
  localparam int SPPA_DAT_W     = 32;
  localparam int SPPA_MEM_DEPTH = 16;
  localparam int SPPA_REG_COUNT = 4;

  // Reset values
  localparam logic [31:0] SPPA_REG_RST   = 32'h0000_0000;
  localparam logic        SPPA_STALL_OFF = 1'h0;

  // Strobe-gating machine of the standard-to-pipelined path
  typedef enum logic [1:0]
  {
    SPPA_GATE_IDLE                       = 2'h1,
    SPPA_GATE_AWAITING_ACKNOWLEDGE_STATE = 2'h2
  } sppa_gate_state_t;

  // Bus master sequencing in the far-end cores
  typedef enum logic [2:0]
  {
    SPPA_MST_IDLE   = 3'h1,
    SPPA_MST_STROBE = 3'h2,
    SPPA_MST_WAIT   = 3'h4
  } sppa_mst_state_t;

endpackage

// ==== logic/sppa_bus_if.sv ====
`timescale 1ns/1ps
// Five bus groups between the adapter and the cores around it:
// sm_ standard master in, ps_ pipelined slave out,
// pm_ pipelined master in, ss_ standard slave out,
// dm_ pipelined master served directly by the adapter's simple slave.
interface sppa_bus_if
#(
  parameter int AW = sppa_pkg::SPPA_ADR_W,
  parameter int DW = sppa_pkg::SPPA_DAT_W
);
  logic          sm_cyc;
  logic          sm_stb;
  logic          sm_we;
  logic [AW-1:0] sm_adr;
  logic [DW-1:0] sm_dat_w;
  logic          sm_ack;
  logic [DW-1:0] sm_dat_r;
  logic          ps_cyc;
  logic          ps_stb;
  logic          ps_we;
  logic [AW-1:0] ps_adr;
  logic [DW-1:0] ps_dat_w;
  logic          ps_ack;
  logic [DW-1:0] ps_dat_r;
  logic          pm_cyc;
  logic          pm_stb;
  logic          pm_we;
  logic [AW-1:0] pm_adr;
  logic [DW-1:0] pm_dat_w;
  logic          pm_stall;
  logic          pm_ack;
  logic [DW-1:0] pm_dat_r;
  logic          ss_cyc;
  logic          ss_stb;
  logic          ss_we;
  logic [AW-1:0] ss_adr;
  logic [DW-1:0] ss_dat_w;
  logic          ss_ack;
  logic [DW-1:0] ss_dat_r;
  logic          dm_cyc;
  logic          dm_stb;
  logic          dm_we;
  logic [AW-1:0] dm_adr;
  logic [DW-1:0] dm_dat_w;
  logic          dm_stall;
  logic          dm_ack;
  logic [DW-1:0] dm_dat_r;

  modport bridge
  (
    input  sm_cyc, sm_stb, sm_we, sm_adr, sm_dat_w,
    output sm_ack, sm_dat_r,
    output ps_cyc, ps_stb, ps_we, ps_adr, ps_dat_w,
    input  ps_ack, ps_dat_r,
    input  pm_cyc, pm_stb, pm_we, pm_adr, pm_dat_w,
    output pm_stall, pm_ack, pm_dat_r,
    output ss_cyc, ss_stb, ss_we, ss_adr, ss_dat_w,
    input  ss_ack, ss_dat_r,
    input  dm_cyc, dm_stb, dm_we, dm_adr, dm_dat_w,
    output dm_stall, dm_ack, dm_dat_r
  );

  modport cores
  (
    output sm_cyc, sm_stb, sm_we, sm_adr, sm_dat_w,
    input  sm_ack, sm_dat_r,
    input  ps_cyc, ps_stb, ps_we, ps_adr, ps_dat_w,
    output ps_ack, ps_dat_r,
    output pm_cyc, pm_stb, pm_we, pm_adr, pm_dat_w,
    input  pm_stall, pm_ack, pm_dat_r,
    input  ss_cyc, ss_stb, ss_we, ss_adr, ss_dat_w,
    output ss_ack, ss_dat_r,
    output dm_cyc, dm_stb, dm_we, dm_adr, dm_dat_w,
    input  dm_stall, dm_ack, dm_dat_r
  );
endinterface

// ==== logic/sppa_bridge_end.sv ====
`timescale 1ns/1ps
// Adapter end: strobe gating, stall generation and a simple register slave
module sppa_bridge_end
#(
  parameter int AW    = sppa_pkg::SPPA_ADR_W,
  parameter int DW    = sppa_pkg::SPPA_DAT_W,
  parameter int NREGS = sppa_pkg::SPPA_REG_COUNT
)
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  sppa_bus_if.bridge         bus,
  output logic               gate_waiting,
  output logic [DW-1:0]      cfg_word
);
  import sppa_pkg::*;

  localparam int IW = (NREGS > 1) ? $clog2(NREGS) : 1;

  sppa_gate_state_t gate_state_reg;
  sppa_gate_state_t gate_state_next;
  logic             ack_reg;
  logic [DW-1:0]    rdat_reg;
  logic [DW-1:0]    regs_reg [NREGS];
  logic             take;
  logic [IW-1:0]    idx;

  // Gating machine: a strobe that reached the slave blocks further ones
  always_comb
  begin
    gate_state_next = gate_state_reg;
    case (gate_state_reg)
      SPPA_GATE_IDLE:
        if (bus.ps_stb)
          gate_state_next = SPPA_GATE_AWAITING_ACKNOWLEDGE_STATE;
      SPPA_GATE_AWAITING_ACKNOWLEDGE_STATE:
        if (bus.ps_ack)
          gate_state_next = SPPA_GATE_IDLE;
      default:
        gate_state_next = SPPA_GATE_IDLE;
    endcase
  end

  // Reset lands idle so the first request passes straight through
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gate_state_reg <= SPPA_GATE_IDLE;
    else
      gate_state_reg <= gate_state_next;
  end

  // Standard master towards pipelined slave; only strobe is altered
  assign bus.ps_stb   = (gate_state_reg == SPPA_GATE_IDLE) ? bus.sm_stb : 1'h0;
  assign bus.ps_cyc   = bus.sm_cyc;
  assign bus.ps_we    = bus.sm_we;
  assign bus.ps_adr   = bus.sm_adr;
  assign bus.ps_dat_w = bus.sm_dat_w;
  assign bus.sm_ack   = bus.ps_ack;
  assign bus.sm_dat_r = bus.ps_dat_r;
  assign gate_waiting = (gate_state_reg == SPPA_GATE_AWAITING_ACKNOWLEDGE_STATE);

  // Pipelined master towards standard slave; stall keeps one request in flight
  assign bus.pm_stall = !bus.ss_cyc ? 1'h0 : !bus.ss_ack;
  assign bus.ss_cyc   = bus.pm_cyc;
  assign bus.ss_stb   = bus.pm_stb;
  assign bus.ss_we    = bus.pm_we;
  assign bus.ss_adr   = bus.pm_adr;
  assign bus.ss_dat_w = bus.pm_dat_w;
  assign bus.pm_ack   = bus.ss_ack;
  assign bus.pm_dat_r = bus.ss_dat_r;

  // Simple slave: registered ack, two-cycle access, write on edge 1
  assign take         = bus.dm_cyc && bus.dm_stb && !ack_reg;
  assign idx          = bus.dm_adr[IW-1:0];
  assign bus.dm_stall = SPPA_STALL_OFF;
  assign bus.dm_ack   = ack_reg;
  assign bus.dm_dat_r = rdat_reg;
  assign cfg_word     = regs_reg[0];

  // Acknowledge comes from a flop, never from the request path
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'h0;
    else
      ack_reg <= take;
  end

  // Register file and read data, both settled on the acknowledging edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdat_reg <= DW'(SPPA_REG_RST);
      for (int i = 0; i < NREGS; i++)
        regs_reg[i] <= DW'(SPPA_REG_RST);
    end
    else if (take)
    begin
      if (bus.dm_we)
        regs_reg[idx] <= bus.dm_dat_w;
      else
        rdat_reg <= regs_reg[idx];
    end
  end

endmodule

// ==== logic/sppa_core_end.sv ====
`timescale 1ns/1ps
// Functional notes
// - Standard master holds strobe until acknowledge
// - Pipelined slave starts transaction every strobe edge
// - Adapter machine: idle, then await acknowledge
// - Slave strobe passes only while machine idle
// - Stalled pipelined master starts nothing new
// - Stall low without cycle, else inverse acknowledge
// - Simple slave: registered ack, two cycles, edge-1 write
// - Direct pipelined master sees stall tied low
// - Write: raise, ack and drop strobe, end
// - Read: raise, data and ack, end
// - One bus clock; outputs launched on rising edge
// - Gated bus clock stops in low state
// - Gate clock only while interconnect idle

// One bus master; PIPE selects pipelined strobe release
module sppa_master
#(
  parameter bit PIPE = 1'b0,
  parameter int AW   = sppa_pkg::SPPA_ADR_W,
  parameter int DW   = sppa_pkg::SPPA_DAT_W
)
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          usr_req,
  input  wire logic          usr_we,
  input  wire logic [AW-1:0] usr_adr,
  input  wire logic [DW-1:0] usr_wdat,
  output logic               usr_ready,
  output logic               usr_done,
  output logic [DW-1:0]      usr_rdat,
  output logic               cyc,
  output logic               stb,
  output logic               we,
  output logic [AW-1:0]      adr,
  output logic [DW-1:0]      dat_w,
  input  wire logic          stall,
  input  wire logic          ack,
  input  wire logic [DW-1:0] dat_r
);
  import sppa_pkg::*;

  sppa_mst_state_t state_reg;
  logic            we_reg;
  logic [AW-1:0]   adr_reg;
  logic [DW-1:0]   wdat_reg;
  logic            done_reg;
  logic [DW-1:0]   rdat_reg;

  // Sequencing; a standard master keeps strobe up until the acknowledge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= SPPA_MST_IDLE;
    else
    begin
      case (state_reg)
        SPPA_MST_IDLE:
          if (usr_req)
            state_reg <= SPPA_MST_STROBE;
        SPPA_MST_STROBE:
          if (ack)
            state_reg <= SPPA_MST_IDLE;
          else if (PIPE && !stall)
            state_reg <= SPPA_MST_WAIT;
        SPPA_MST_WAIT:
          if (ack)
            state_reg <= SPPA_MST_IDLE;
        default:
          state_reg <= SPPA_MST_IDLE;
      endcase
    end
  end

  // Request fields are frozen for the whole cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      we_reg   <= 1'h0;
      adr_reg  <= '0;
      wdat_reg <= '0;
    end
    else if (state_reg == SPPA_MST_IDLE && usr_req)
    begin
      we_reg   <= usr_we;
      adr_reg  <= usr_adr;
      wdat_reg <= usr_wdat;
    end
  end

  // Completion pulse and captured read data
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_reg <= 1'h0;
      rdat_reg <= '0;
    end
    else
    begin
      done_reg <= (state_reg != SPPA_MST_IDLE) && ack;
      if ((state_reg != SPPA_MST_IDLE) && ack && !we_reg)
        rdat_reg <= dat_r;
    end
  end

  // Strobe only in the strobe state; cycle spans strobe and wait
  assign cyc       = (state_reg != SPPA_MST_IDLE);
  assign stb       = (state_reg == SPPA_MST_STROBE);
  assign we        = we_reg;
  assign adr       = adr_reg;
  assign dat_w     = wdat_reg;
  assign usr_ready = (state_reg == SPPA_MST_IDLE);
  assign usr_done  = done_reg;
  assign usr_rdat  = rdat_reg;

endmodule

// One memory slave; PIPE takes a new request on every strobe
module sppa_slave
#(
  parameter bit PIPE  = 1'b0,
  parameter int AW    = sppa_pkg::SPPA_ADR_W,
  parameter int DW    = sppa_pkg::SPPA_DAT_W,
  parameter int DEPTH = sppa_pkg::SPPA_MEM_DEPTH
)
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          cyc,
  input  wire logic          stb,
  input  wire logic          we,
  input  wire logic [AW-1:0] adr,
  input  wire logic [DW-1:0] dat_w,
  output logic               ack,
  output logic [DW-1:0]      dat_r
);
  import sppa_pkg::*;

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic          ack_reg;
  logic [DW-1:0] rdat_reg;
  logic [DW-1:0] mem [DEPTH];
  logic          take;
  logic [IW-1:0] idx;

  // Standard mode ignores the strobe it has just acknowledged
  assign take = PIPE ? (cyc && stb) : (cyc && stb && !ack_reg);
  assign idx  = adr[IW-1:0];

  // Acknowledge one edge after each accepted request
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'h0;
    else
      ack_reg <= take;
  end

  // Read data launched on the same edge as the acknowledge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdat_reg <= '0;
    else if (take && !we)
      rdat_reg <= mem[idx];
  end

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge sys_clk)
  begin
    if (take && we)
      mem[idx] <= dat_w;
  end

  assign ack   = ack_reg;
  assign dat_r = rdat_reg;

endmodule

// Far end: three masters and two slaves around the adapter.
// Index 0 drives the standard master, 1 the pipelined master behind
// the stall logic, 2 the pipelined master on the direct simple slave.
// The bus clock is assumed free running; any gating of it is done
// outside, stopped low and only while every cycle line is low.
module sppa_core_end
#(
  parameter int AW    = sppa_pkg::SPPA_ADR_W,
  parameter int DW    = sppa_pkg::SPPA_DAT_W,
  parameter int DEPTH = sppa_pkg::SPPA_MEM_DEPTH
)
(
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  sppa_bus_if.cores                bus,
  input  wire logic [2:0]          usr_req,
  input  wire logic [2:0]          usr_we,
  input  wire logic [2:0][AW-1:0]  usr_adr,
  input  wire logic [2:0][DW-1:0]  usr_wdat,
  output logic [2:0]               usr_ready,
  output logic [2:0]               usr_done,
  output logic [2:0][DW-1:0]       usr_rdat,
  output logic                     bus_idle
);
  import sppa_pkg::*;

  // Standard master; no stall in standard mode
  sppa_master #(.PIPE(1'b0), .AW(AW), .DW(DW)) u_std_master
  (
    .sys_clk (sys_clk), .rst_n (rst_n), .usr_req (usr_req[0]), .usr_we (usr_we[0]),
    .usr_adr (usr_adr[0]), .usr_wdat (usr_wdat[0]), .usr_ready (usr_ready[0]),
    .usr_done (usr_done[0]), .usr_rdat (usr_rdat[0]), .cyc (bus.sm_cyc), .stb (bus.sm_stb),
    .we (bus.sm_we), .adr (bus.sm_adr), .dat_w (bus.sm_dat_w), .stall (SPPA_STALL_OFF),
    .ack (bus.sm_ack), .dat_r (bus.sm_dat_r)
  );

  // Pipelined master held back by the adapter's stall
  sppa_master #(.PIPE(1'b1), .AW(AW), .DW(DW)) u_pipe_master
  (
    .sys_clk (sys_clk), .rst_n (rst_n), .usr_req (usr_req[1]), .usr_we (usr_we[1]),
    .usr_adr (usr_adr[1]), .usr_wdat (usr_wdat[1]), .usr_ready (usr_ready[1]),
    .usr_done (usr_done[1]), .usr_rdat (usr_rdat[1]), .cyc (bus.pm_cyc), .stb (bus.pm_stb),
    .we (bus.pm_we), .adr (bus.pm_adr), .dat_w (bus.pm_dat_w), .stall (bus.pm_stall),
    .ack (bus.pm_ack), .dat_r (bus.pm_dat_r)
  );

  // Pipelined master on the simple slave; its stall stays low
  sppa_master #(.PIPE(1'b1), .AW(AW), .DW(DW)) u_direct_master
  (
    .sys_clk (sys_clk), .rst_n (rst_n), .usr_req (usr_req[2]), .usr_we (usr_we[2]),
    .usr_adr (usr_adr[2]), .usr_wdat (usr_wdat[2]), .usr_ready (usr_ready[2]),
    .usr_done (usr_done[2]), .usr_rdat (usr_rdat[2]), .cyc (bus.dm_cyc), .stb (bus.dm_stb),
    .we (bus.dm_we), .adr (bus.dm_adr), .dat_w (bus.dm_dat_w), .stall (bus.dm_stall),
    .ack (bus.dm_ack), .dat_r (bus.dm_dat_r)
  );

  // Pipelined slave behind the strobe gate
  sppa_slave #(.PIPE(1'b1), .AW(AW), .DW(DW), .DEPTH(DEPTH)) u_pipe_slave
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cyc     (bus.ps_cyc),
    .stb     (bus.ps_stb),
    .we      (bus.ps_we),
    .adr     (bus.ps_adr),
    .dat_w   (bus.ps_dat_w),
    .ack     (bus.ps_ack),
    .dat_r   (bus.ps_dat_r)
  );

  // Standard slave behind the stall logic
  sppa_slave #(.PIPE(1'b0), .AW(AW), .DW(DW), .DEPTH(DEPTH)) u_std_slave
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .cyc     (bus.ss_cyc),
    .stb     (bus.ss_stb),
    .we      (bus.ss_we),
    .adr     (bus.ss_adr),
    .dat_w   (bus.ss_dat_w),
    .ack     (bus.ss_ack),
    .dat_r   (bus.ss_dat_r)
  );

  // Safe point for an outside clock gate: no cycle open on any path
  assign bus_idle = !bus.sm_cyc && !bus.pm_cyc && !bus.dm_cyc;

endmodule

// ==== verification/sppa_bus_chk.sv ====
`timescale 1ns/1ps
// Protocol watch on the adapter interface; sees only interface signals
module sppa_bus_chk
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sm_stb,
  input wire logic sm_ack,
  input wire logic ps_stb,
  input wire logic ps_ack,
  input wire logic pm_stb,
  input wire logic pm_stall,
  input wire logic ss_cyc,
  input wire logic ss_stb,
  input wire logic ss_ack,
  input wire logic dm_cyc,
  input wire logic dm_stb,
  input wire logic dm_we,
  input wire logic dm_ack,
  input wire logic dm_stall
);
  logic wait_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Shadow of the gate machine, so the gating is judged without its state port
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_reg <= 1'b0;
    else if (ps_stb)
      wait_reg <= 1'b1;
    else if (ps_ack)
      wait_reg <= 1'b0;
  end

  a_gate_masks_strobe: assert property (wait_reg |-> !ps_stb)
    else $error("slave strobe high while awaiting acknowledge");
  a_gate_passes_idle: assert property (!wait_reg |-> ps_stb == sm_stb)
    else $error("master strobe not passed while idle");
  a_pipe_slave_ack: assert property (ps_stb |=> ps_ack)
    else $error("pipelined slave missed a strobe");
  a_std_strobe_hold: assert property (sm_stb && !sm_ack |=> sm_stb)
    else $error("standard master dropped strobe before acknowledge");
  a_stall_formula: assert property (pm_stall == (ss_cyc && !ss_ack))
    else $error("stall not derived from slave cycle and acknowledge");
  a_stalled_holds: assert property (pm_stall && pm_stb |=> pm_stb)
    else $error("stalled master changed its request");
  a_std_slave_ack: assert property (ss_cyc && ss_stb && !ss_ack |=> ss_ack)
    else $error("standard slave did not answer");
  a_direct_no_stall: assert property (!dm_stall)
    else $error("direct stall not held low");
  a_direct_ack_reg: assert property (dm_cyc && dm_stb && !dm_ack |=> dm_ack)
    else $error("simple slave acknowledge not one edge after request");
  a_direct_ack_pulse: assert property (dm_ack |=> !dm_ack)
    else $error("simple slave acknowledge longer than one cycle");
  a_direct_write_seq: assert property ($rose(dm_stb) && dm_we |=>
    dm_cyc && !dm_stb && dm_ack ##1 !dm_cyc)
    else $error("direct write sequence broken");
  a_direct_read_seq: assert property ($rose(dm_stb) && !dm_we |=>
    dm_cyc && !dm_stb && dm_ack ##1 !dm_cyc)
    else $error("direct read sequence broken");
endmodule

// ==== verification/standard_pipelined_bus_adapter_bench.sv ====
`timescale 1ns/1ps
module standard_pipelined_bus_adapter_bench;
  import sppa_pkg::*;

  logic                 sys_clk;
  logic                 rst_n;
  logic [2:0]           usr_req;
  logic [2:0]           usr_we;
  logic [2:0][7:0]      usr_adr;
  logic [2:0][31:0]     usr_wdat;
  logic [2:0]           usr_ready;
  logic [2:0]           usr_done;
  logic [2:0][31:0]     usr_rdat;
  logic                 bus_idle;
  logic                 gate_waiting;
  logic [31:0]          cfg_word;
  int                   mismatches;
  int                   compares;

  sppa_bus_if bus();
  sppa_bridge_end sppa_bridge_end_i(.sys_clk, .rst_n, .bus(bus), .gate_waiting, .cfg_word);
  sppa_core_end sppa_core_end_i(.sys_clk, .rst_n, .bus(bus), .usr_req, .usr_we, .usr_adr,
    .usr_wdat, .usr_ready, .usr_done, .usr_rdat, .bus_idle);
  sppa_bus_chk sppa_bus_chk_i(.sys_clk, .rst_n, .sm_stb(bus.sm_stb), .sm_ack(bus.sm_ack),
    .ps_stb(bus.ps_stb), .ps_ack(bus.ps_ack), .pm_stb(bus.pm_stb), .pm_stall(bus.pm_stall),
    .ss_cyc(bus.ss_cyc), .ss_stb(bus.ss_stb), .ss_ack(bus.ss_ack), .dm_cyc(bus.dm_cyc),
    .dm_stb(bus.dm_stb), .dm_we(bus.dm_we), .dm_ack(bus.dm_ack), .dm_stall(bus.dm_stall));

  // 40 MHz bus clock
  always #12.5 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One user transfer; probes the bus mid-flight and checks the three-cycle answer
  task automatic xfer(input int i, input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    chk("usr_ready", 1, usr_ready[i]);
    usr_we[i] = w;
    usr_adr[i] = a;
    usr_wdat[i] = d;
    usr_req[i] = 1'b1;
    @(negedge sys_clk);
    usr_req[i] = 1'b0;
    n = 1;
    while (usr_done[i] !== 1'b1 && n < 8)
    begin
      if (i == 0 && n == 1) chk("ps_stb", 1, bus.ps_stb);
      if (i == 0 && n == 2) chk("gate_waiting", 1, gate_waiting);
      if (i == 0 && n == 2) chk("ps_stb_masked", 0, bus.ps_stb);
      if (i == 1) chk("pm_stall", n == 1, bus.pm_stall);
      if (i == 2 && n == 2) chk("dm_ack", 1, bus.dm_ack);
      if (n == 1) chk("bus_idle_busy", 0, bus_idle);
      @(negedge sys_clk);
      n++;
    end
    chk("latency", 3, n);
    if (i == 0) chk("gate_back_idle", 0, gate_waiting);
  endtask

  // Reset leaves the gate idle and every stall low
  task automatic t_reset();
    chk("gate_waiting", 0, gate_waiting);
    chk("pm_stall", 0, bus.pm_stall);
    chk("dm_stall", 0, bus.dm_stall);
    chk("cfg_word", 32'h0000_0000, cfg_word);
  endtask

  // Simple slave on the direct path: all four words, writes then reads back to back
  task automatic t_direct();
    for (int a = 0; a < 4; a++)
      xfer(2, 1'b1, 8'(a), 32'hA5A5_0000 + 32'(a));
    chk("cfg_word", 32'hA5A5_0000, cfg_word);
    for (int a = 0; a < 4; a++)
    begin
      xfer(2, 1'b0, 8'(a), 32'h0000_0000);
      chk("dm_rdat", 32'hA5A5_0000 + 32'(a), usr_rdat[2]);
    end
  endtask

  // Standard master to pipelined slave, and pipelined master to standard slave
  task automatic t_cross(input int i);
    xfer(i, 1'b1, 8'h0F, 32'hC3C3_1234 + 32'(i));
    xfer(i, 1'b1, 8'h00, 32'h5A5A_FFFF);
    xfer(i, 1'b0, 8'h0F, 32'h0000_0000);
    chk("rdat_hi", 32'hC3C3_1234 + 32'(i), usr_rdat[i]);
    xfer(i, 1'b0, 8'h00, 32'h0000_0000);
    chk("rdat_lo", 32'h5A5A_FFFF, usr_rdat[i]);
  endtask

  // All three paths at once; bus must fall idle afterwards
  task automatic t_together();
    fork
      xfer(0, 1'b1, 8'h07, 32'h1111_0000);
      xfer(1, 1'b1, 8'h07, 32'h2222_0000);
      xfer(2, 1'b1, 8'h01, 32'h3333_0000);
    join
    @(negedge sys_clk);
    chk("bus_idle", 1, bus_idle);
    fork
      xfer(0, 1'b0, 8'h07, 32'h0000_0000);
      xfer(1, 1'b0, 8'h07, 32'h0000_0000);
    join
    chk("rdat0", 32'h1111_0000, usr_rdat[0]);
    chk("rdat1", 32'h2222_0000, usr_rdat[1]);
  endtask

  // Main sequence
  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    usr_req = 3'h0;
    usr_we = 3'h0;
    usr_adr = '0;
    usr_wdat = '0;
    mismatches = 0;
    compares = 0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    rst_n = 1'b1;
    @(negedge sys_clk);
    t_direct();
    t_cross(0);
    t_cross(1);
    t_together();
    summarize();
  end

  // Watchdog: the sequence needs well under 200 cycles
  initial
  begin
    repeat (2000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
endmodule
